// file: scsl_pkg.sv
/*
  Shared constants and types of the supply control and status logic.
  Assumes a single 100 MHz clock; all intervals are kept in microseconds.
*/
package scsl_pkg;
  // Clock rate in MHz, intervals in microseconds, counter widths in bits.
  localparam int CLK_MHZ       = 100;
  localparam int DEBOUNCE_US   = 5000;
  localparam int LOCKOUT_US    = 5000;
  localparam int ADDR_DEB_US   = 5000;
  localparam int STARTUP_US    = 100000;
  localparam int BLINK_HALF_US = 250000;
  localparam int FAST_HALF_US  = 62500;
  localparam int TW            = 18;
  localparam int DW            = 13;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ_STS  = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  // Control register fields.
  localparam int         CTRL_W    = 3;
  localparam int         CTRL_AUX  = 0;
  localparam int         CTRL_PRIO = 1;
  localparam int         CTRL_OVR  = 2;
  localparam logic [2:0] CTRL_RST  = 3'h0;
  // Status register fields.
  localparam int STS_STATE = 0;
  localparam int STS_AUX   = 3;
  localparam int STS_MAIN  = 4;
  localparam int STS_AV    = 5;
  localparam int STS_EN    = 6;
  localparam int STS_INH   = 7;
  localparam int STS_ADDR  = 8;
  // Interrupt status and mask fields.
  localparam int         IRQ_W     = 4;
  localparam int         IRQ_FAULT = 0;
  localparam int         IRQ_CRIT  = 1;
  localparam int         IRQ_READY = 2;
  localparam int         IRQ_ADDR  = 3;
  localparam logic [3:0] IRQ_RST   = 4'h0;
  // Management address and bus responses.
  localparam logic [6:0] MGMT_ADDR_BASE = 7'h20;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_DECERR    = 2'h3;

  typedef enum logic [2:0] {
    ST_START, ST_CRIT, ST_READY, ST_RUN, ST_FAULT
  } scsl_state_type;

  typedef struct packed {
    logic red;
    logic green;
  } scsl_led_type;

  typedef struct packed {
    logic out;
    logic oe;
  } scsl_od_type;

  typedef struct packed {
    logic ot;
    logic ov;
    logic uv;
    logic oc;
    logic crit;
  } scsl_fault_type;
endpackage

// file: scsl_debounce.sv
/*
  Single-pin debounce filter for an active-low input.
  Assumes a one-cycle microsecond tick and a pin synchronous to aclk.
*/
`timescale 1ns/1ns
module scsl_debounce #(
  parameter int STABLE_US = 5000
) (
  // Clock, reset and timebase.
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          tick_us,
  // Raw pin and filtered result.
  input  wire logic          pin_n,
  output logic               level_reg,
  output logic               settled_reg
);
  import scsl_pkg::*;

  logic          samp_reg, samp_next;
  logic [DW-1:0] cnt_reg, cnt_next;
  logic          level_next, settled_next;

  // A level is taken only after it held for the full interval; any
  // change of the pin restarts the count, so glitches never pass.
  always_comb begin
    samp_next    = samp_reg;
    cnt_next     = cnt_reg;
    level_next   = level_reg;
    settled_next = settled_reg;
    if (pin_n != samp_reg) begin
      samp_next = pin_n;
      cnt_next  = '0;
    end else if (tick_us && cnt_reg != DW'(STABLE_US)) begin
      cnt_next = cnt_reg + DW'(1);
    end
    if (cnt_reg == DW'(STABLE_US)) begin
      level_next   = samp_reg;
      settled_next = 1'b1;
    end
  end

  // Inactive level after reset models the internal pull-up.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp_reg    <= 1'b1;
      cnt_reg     <= '0;
      level_reg   <= 1'b1;
      settled_reg <= 1'b0;
    end else begin
      samp_reg    <= samp_next;
      cnt_reg     <= cnt_next;
      level_reg   <= level_next;
      settled_reg <= settled_next;
    end
  end
endmodule

// file: scsl_top.sv
/*
  Control and status logic of a DC-DC power module: pin debounce,
  output gating with lockout, address latch, indicator and open-drain
  lines, and an AXI4-Lite register slave with one interrupt.
  Assumes one free-running clock, synchronous inputs and analog
  supervision delivered as clean fault and start-up levels.
*/
`timescale 1ns/1ns
// Behaviour
// - Aux output follows the aux enable pin or the control bit.
// - Main inhibit gates the other outputs, only while aux enable is low.
// - Enable, inhibit and address inputs idle at one, the inactive level.
// - Enable and inhibit edges are accepted after a stable debounce interval.
// - Successive main enables are separated by a lockout interval.
// - Address pins are debounced at start-up then held until power cycle.
// - Address is 20h plus inverted bit one and bit zero pins.
// - One red/green indicator; fail and hold lines change with it.
// - During start-up show steady red and pull both lines low.
// - Start-up red beyond 100 ms becomes a permanent critical fault.
// - Ready: blinking green, hold released, fail released.
// - Outputs good with aux enabled: steady green, both lines released.
// - Operating fault: blinking red, fail low, hold released.
// - Software priority shows fast blinking green.
// - Protection override blinks green and red alternately.
// - Fail and hold lines only pull low or release.
module scsl_top
  import scsl_pkg::*;
#(
  parameter int CLK_FREQ_MHZ  = CLK_MHZ,
  parameter int DEB_US        = DEBOUNCE_US,
  parameter int LOCK_US       = LOCKOUT_US,
  parameter int ADDR_US       = ADDR_DEB_US,
  parameter int START_US      = STARTUP_US,
  parameter int BLINK_US      = BLINK_HALF_US,
  parameter int FAST_US       = FAST_HALF_US
) (
  // Clock and reset.
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Backplane control pins, active low.
  input  wire logic                  aux_enable_n,
  input  wire logic                  main_inhibit_n,
  input  wire logic                  slot_addr_bit0_n,
  input  wire logic                  slot_addr_bit1_n,
  // Analog supervision.
  input  wire logic                  startup_done,
  input  wire scsl_pkg::scsl_fault_type fault_in,
  // Power stage controls and management address.
  output logic                       aux_on_reg,
  output logic                       main_on_reg,
  output logic                       addr_valid_reg,
  output logic [6:0]                 mgmt_addr_reg,
  // Indicator, open-drain lines and interrupt.
  output scsl_pkg::scsl_led_type     led_reg,
  output scsl_pkg::scsl_od_type      fail_n_reg,
  output scsl_pkg::scsl_od_type      backplane_hold_n_reg,
  output logic                       irq_reg
);
  import scsl_pkg::*;

  logic [7:0]        tick_cnt_reg, tick_cnt_next;
  logic              tick_reg, tick_next;
  logic              en_lvl, inh_lvl, ga0_lvl, ga1_lvl, ga0_ok, ga1_ok;
  scsl_state_type    state_reg, state_next;
  logic [TW-1:0]     start_reg, start_next, lock_reg, lock_next;
  logic [TW-1:0]     slow_reg, slow_next, fast_reg, fast_next;
  logic              slow_ph_reg, slow_ph_next, fast_ph_reg, fast_ph_next;
  logic              aux_on_next, main_on_next, addr_valid_next, irq_next;
  logic [6:0]        mgmt_addr_next;
  scsl_led_type      led_next;
  scsl_od_type       fail_n_next, hold_n_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0]  sts_reg, sts_next, mask_reg, mask_next, ev, rd_clr;
  logic              aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0]        awa_reg, awa_next;
  logic [31:0]       wd_reg, wd_next, rdata_next;
  logic [3:0]        ws_reg, ws_next;
  logic              bvalid_next, rvalid_next, awready_next, wready_next;
  logic              arready_next;
  logic [1:0]        bresp_next, rresp_next;
  logic              fault_any, prio, ovr;

  // Microsecond tick; every interval below counts these ticks.
  always_comb begin
    tick_next     = 1'b0;
    tick_cnt_next = tick_cnt_reg + 8'h01;
    if (tick_cnt_reg == 8'(CLK_FREQ_MHZ - 1)) begin
      tick_cnt_next = 8'h00;
      tick_next     = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 8'h00;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // Four pin filters; the address pins use their own interval.
  scsl_debounce #(.STABLE_US(DEB_US)) u_en (
    .aclk(aclk), .aresetn(aresetn), .tick_us(tick_reg),
    .pin_n(aux_enable_n), .level_reg(en_lvl), .settled_reg());
  scsl_debounce #(.STABLE_US(DEB_US)) u_inh (
    .aclk(aclk), .aresetn(aresetn), .tick_us(tick_reg),
    .pin_n(main_inhibit_n), .level_reg(inh_lvl), .settled_reg());
  scsl_debounce #(.STABLE_US(ADDR_US)) u_ga0 (
    .aclk(aclk), .aresetn(aresetn), .tick_us(tick_reg),
    .pin_n(slot_addr_bit0_n), .level_reg(ga0_lvl),
    .settled_reg(ga0_ok));
  scsl_debounce #(.STABLE_US(ADDR_US)) u_ga1 (
    .aclk(aclk), .aresetn(aresetn), .tick_us(tick_reg),
    .pin_n(slot_addr_bit1_n), .level_reg(ga1_lvl),
    .settled_reg(ga1_ok));

  assign fault_any = |fault_in;
  assign prio      = ctrl_reg[CTRL_PRIO];
  assign ovr       = ctrl_reg[CTRL_OVR];

  // Sequencer, output gating, address latch, indicator and lines. The
  // indicator and both lines come from the same next state, so they
  // always change on the same edge.
  always_comb begin
    state_next      = state_reg;
    start_next      = start_reg;
    lock_next       = lock_reg;
    slow_next       = slow_reg;
    fast_next       = fast_reg;
    slow_ph_next    = slow_ph_reg;
    fast_ph_next    = fast_ph_reg;
    mgmt_addr_next  = mgmt_addr_reg;
    addr_valid_next = addr_valid_reg;
    if (tick_reg) begin
      slow_next = slow_reg + TW'(1);
      fast_next = fast_reg + TW'(1);
      if (slow_reg == TW'(BLINK_US - 1)) begin
        slow_next    = '0;
        slow_ph_next = !slow_ph_reg;
      end
      if (fast_reg == TW'(FAST_US - 1)) begin
        fast_next    = '0;
        fast_ph_next = !fast_ph_reg;
      end
      if (lock_reg != '0) begin
        lock_next = lock_reg - TW'(1);
      end
      if (state_reg == ST_START && start_reg != TW'(START_US)) begin
        start_next = start_reg + TW'(1);
      end
    end
    // Address is caught once and never revisited until reset.
    if (!addr_valid_reg && ga0_ok && ga1_ok) begin
      addr_valid_next = 1'b1;
      mgmt_addr_next  = MGMT_ADDR_BASE | {5'h00, !ga1_lvl, !ga0_lvl};
    end
    aux_on_next  = !en_lvl || ctrl_reg[CTRL_AUX];
    main_on_next = main_on_reg;
    // Inhibit low keeps only the aux output; inhibit high frees the rest.
    if (en_lvl || !inh_lvl) begin
      main_on_next = 1'b0;
    end else if (!main_on_reg && lock_reg == '0) begin
      main_on_next = 1'b1;
      lock_next    = TW'(LOCK_US);
    end
    case (state_reg)
      ST_START: begin
        if (startup_done && !fault_any) begin
          state_next = ST_READY;
        end else if (start_reg == TW'(START_US)) begin
          state_next = ST_CRIT;
        end
      end
      ST_CRIT:  state_next = ST_CRIT;
      ST_READY: begin
        if (fault_any) begin
          state_next = ST_FAULT;
        end else if (aux_on_reg) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault_any) begin
          state_next = ST_FAULT;
        end else if (!aux_on_reg) begin
          state_next = ST_READY;
        end
      end
      ST_FAULT: begin
        if (!fault_any) begin
          state_next = ST_READY;
        end
      end
      default:  state_next = ST_START;
    endcase
    // Lines only ever pull low or let go; out stays zero.
    fail_n_next = '{out: 1'b0, oe: 1'b0};
    hold_n_next = '{out: 1'b0, oe: 1'b0};
    led_next    = '{red: 1'b0, green: 1'b1};
    case (state_next)
      ST_START, ST_CRIT: begin
        led_next       = '{red: 1'b1, green: 1'b0};
        fail_n_next.oe = 1'b1;
        hold_n_next.oe = 1'b1;
      end
      ST_FAULT: begin
        led_next       = '{red: slow_ph_next, green: 1'b0};
        fail_n_next.oe = 1'b1;
      end
      ST_READY: led_next = '{red: 1'b0, green: slow_ph_next};
      default:  led_next = '{red: 1'b0, green: 1'b1};
    endcase
    // Faults are handled above, so these never mask a fault display.
    if (state_next == ST_READY || state_next == ST_RUN) begin
      if (ovr) begin
        led_next = '{red: !slow_ph_next, green: slow_ph_next};
      end else if (prio) begin
        led_next = '{red: 1'b0, green: fast_ph_next};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg            <= ST_START;
      start_reg            <= '0;
      lock_reg             <= '0;
      slow_reg             <= '0;
      fast_reg             <= '0;
      slow_ph_reg          <= 1'b0;
      fast_ph_reg          <= 1'b0;
      aux_on_reg           <= 1'b0;
      main_on_reg          <= 1'b0;
      addr_valid_reg       <= 1'b0;
      mgmt_addr_reg        <= MGMT_ADDR_BASE;
      led_reg              <= '{red: 1'b1, green: 1'b0};
      fail_n_reg           <= '{out: 1'b0, oe: 1'b1};
      backplane_hold_n_reg <= '{out: 1'b0, oe: 1'b1};
    end else begin
      state_reg            <= state_next;
      start_reg            <= start_next;
      lock_reg             <= lock_next;
      slow_reg             <= slow_next;
      fast_reg             <= fast_next;
      slow_ph_reg          <= slow_ph_next;
      fast_ph_reg          <= fast_ph_next;
      aux_on_reg           <= aux_on_next;
      main_on_reg          <= main_on_next;
      addr_valid_reg       <= addr_valid_next;
      mgmt_addr_reg        <= mgmt_addr_next;
      led_reg              <= led_next;
      fail_n_reg           <= fail_n_next;
      backplane_hold_n_reg <= hold_n_next;
    end
  end

  // Events into sticky status; a set in the clearing cycle survives.
  assign ev[IRQ_FAULT] = state_next == ST_FAULT && state_reg != ST_FAULT;
  assign ev[IRQ_CRIT]  = state_next == ST_CRIT && state_reg != ST_CRIT;
  assign ev[IRQ_READY] = state_next == ST_READY && state_reg == ST_START;
  assign ev[IRQ_ADDR]  = addr_valid_next && !addr_valid_reg;

  // Register slave: write address and data are held until both are in,
  // then one response; one read answered per accepted address.
  always_comb begin
    aw_have_next = aw_have_reg;
    w_have_next  = w_have_reg;
    awa_next     = awa_reg;
    wd_next      = wd_reg;
    ws_next      = ws_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    rvalid_next  = s_axi_rvalid;
    rresp_next   = s_axi_rresp;
    rdata_next   = s_axi_rdata;
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    rd_clr       = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      awa_next     = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      wd_next     = s_axi_wdata;
      ws_next     = s_axi_wstrb;
    end
    if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      case (awa_reg)
        OFS_CTRL: if (ws_reg[0]) ctrl_next = wd_reg[CTRL_W-1:0];
        OFS_IRQ_MASK: if (ws_reg[0]) mask_next = wd_reg[IRQ_W-1:0];
        OFS_STATUS, OFS_IRQ_STS: bresp_next = RESP_OKAY;
        default:  bresp_next = RESP_DECERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CTRL:     rdata_next[CTRL_W-1:0] = ctrl_reg;
        OFS_STATUS: begin
          rdata_next[STS_STATE +: 3] = state_reg;
          rdata_next[STS_AUX]        = aux_on_reg;
          rdata_next[STS_MAIN]       = main_on_reg;
          rdata_next[STS_AV]         = addr_valid_reg;
          rdata_next[STS_EN]         = en_lvl;
          rdata_next[STS_INH]        = inh_lvl;
          rdata_next[STS_ADDR +: 7]  = mgmt_addr_reg;
        end
        OFS_IRQ_STS: begin
          rdata_next[IRQ_W-1:0] = sts_reg;
          rd_clr                = sts_reg;
        end
        OFS_IRQ_MASK: rdata_next[IRQ_W-1:0] = mask_reg;
        default:      rresp_next = RESP_DECERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next  = !w_have_next && !bvalid_next;
    arready_next = !rvalid_next;
    sts_next     = (sts_reg & ~rd_clr) | ev;
    irq_next     = |(sts_next & mask_next);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awa_reg       <= 8'h00;
      wd_reg        <= 32'h0000_0000;
      ws_reg        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      ctrl_reg      <= CTRL_RST;
      mask_reg      <= IRQ_RST;
      sts_reg       <= IRQ_RST;
      irq_reg       <= 1'b0;
    end else begin
      aw_have_reg   <= aw_have_next;
      w_have_reg    <= w_have_next;
      awa_reg       <= awa_next;
      wd_reg        <= wd_next;
      ws_reg        <= ws_next;
      s_axi_awready <= awready_next;
      s_axi_wready  <= wready_next;
      s_axi_bvalid  <= bvalid_next;
      s_axi_bresp   <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid  <= rvalid_next;
      s_axi_rresp   <= rresp_next;
      s_axi_rdata   <= rdata_next;
      ctrl_reg      <= ctrl_next;
      mask_reg      <= mask_next;
      sts_reg       <= sts_next;
      irq_reg       <= irq_next;
    end
  end

  // Checks on the sequencer and pins.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The indicator register was built from the control bits one cycle
  // earlier, so the display checks look at the past control value.
  a_aux_follows: assert property (
    aux_on_reg == $past(!en_lvl || ctrl_reg[CTRL_AUX]))
    else $error("aux output wrong");
  a_main_gated: assert property (
    main_on_reg |-> $past(!en_lvl && inh_lvl))
    else $error("main on without pins");
  a_lock_holds: assert property (
    (lock_reg != '0 && !main_on_reg) |=> !main_on_reg)
    else $error("restart in lockout");
  a_addr_frozen: assert property (
    addr_valid_reg && $past(addr_valid_reg) |-> $stable(mgmt_addr_reg))
    else $error("address moved");
  a_addr_map: assert property (
    $rose(addr_valid_reg) |-> mgmt_addr_reg == (MGMT_ADDR_BASE |
      {5'h00, !$past(ga1_lvl), !$past(ga0_lvl)}))
    else $error("bad address");
  a_start_red: assert property (
    state_reg == ST_START |-> led_reg.red && !led_reg.green &&
      fail_n_reg.oe && backplane_hold_n_reg.oe)
    else $error("start display wrong");
  a_crit_sticks: assert property (
    state_reg == ST_CRIT |=> state_reg == ST_CRIT && led_reg.red)
    else $error("critical left");
  a_ready_lines: assert property (
    state_reg == ST_READY |-> !fail_n_reg.oe &&
      !backplane_hold_n_reg.oe && (!led_reg.red || $past(ovr)))
    else $error("ready lines wrong");
  a_run_green: assert property (
    state_reg == ST_RUN && !$past(prio) && !$past(ovr) |->
      led_reg.green && !led_reg.red)
    else $error("run not green");
  a_fault_lines: assert property (
    state_reg == ST_FAULT |-> fail_n_reg.oe &&
      !backplane_hold_n_reg.oe && !led_reg.green)
    else $error("fault lines wrong");
  a_prio_fast: assert property (
    state_reg == ST_RUN && $past(prio) && !$past(ovr) |->
      led_reg.green == fast_ph_reg)
    else $error("priority blink wrong");
  a_ovr_alt: assert property (
    state_reg == ST_RUN && $past(ovr) |-> led_reg.red != led_reg.green)
    else $error("override blink wrong");
  a_od_low_only: assert property (
    !fail_n_reg.out && !backplane_hold_n_reg.out)
    else $error("line driven high");

  c_run: cover property (state_reg == ST_READY ##1 state_reg == ST_RUN);
  c_fault: cover property (state_reg == ST_RUN ##1 state_reg == ST_FAULT);
  c_crit: cover property (state_reg == ST_START ##1 state_reg == ST_CRIT);
  c_main: cover property ($rose(main_on_reg));
endmodule

// file: scsl_ctrl_model.sv
/*
  Backplane controller model that drives the block's control pins.
  Assumes the bench sets its wishes just after a rising clock edge.
*/
`timescale 1ns/1ns
module scsl_ctrl_model (
  // Clock.
  input  wire logic       aclk,
  // Wishes of the controller, active high.
  input  wire logic       want_aux,
  input  wire logic       want_inhibit,
  input  wire logic [1:0] strap,
  // Control pins, active low, idle high.
  output logic            aux_enable_n     = 1'b1,
  output logic            main_inhibit_n   = 1'b1,
  output logic            slot_addr_bit0_n = 1'b1,
  output logic            slot_addr_bit1_n = 1'b1
);
  // Pins move only at edges, so the block never sees a mid-cycle change.
  always @(posedge aclk) begin
    aux_enable_n     <= !want_aux;
    main_inhibit_n   <= !want_inhibit;
    slot_addr_bit0_n <= !strap[0];
    slot_addr_bit1_n <= !strap[1];
  end
endmodule

// file: tb_top.sv
/*
  Self-checking bench of the supply control and status logic.
  Assumes tiny interval parameters so each interval lasts at most 100 cycles.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: %h, expected %h", $time, a, b); end end
`define WT(c) begin k = 0; while (!(c) && k < 300) begin \
  @(posedge aclk); k++; end if (!(c)) fail_count++; end
module tb_top;
  import scsl_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, aux_on_reg, main_on_reg, addr_valid_reg, irq_reg;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs, seen, strap = 2'b00;
  logic aux_enable_n, main_inhibit_n, slot_addr_bit0_n, slot_addr_bit1_n;
  logic want_aux = 1'b0, want_inhibit = 1'b1, startup_done = 1'b0;
  logic [6:0] mgmt_addr_reg;
  scsl_fault_type fault_in = '0;
  scsl_led_type led_reg, prev;
  scsl_od_type fail_n_reg, backplane_hold_n_reg;
  int fail_count = 0, n_tests = 0, k, i, n;
  logic [8:0] rows [4] = '{9'h020, 9'h0A1, 9'h122, 9'h1A3};
  scsl_top #(.CLK_FREQ_MHZ(2), .DEB_US(5), .LOCK_US(20), .ADDR_US(5),
    .START_US(50), .BLINK_US(4), .FAST_US(2)) scsl_top_i (.*);
  scsl_ctrl_model scsl_ctrl_model_i (.*);
  // A 100 MHz clock.
  always #5 aclk = ~aclk;
  task automatic rst();
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ga, gw;
    @(posedge aclk);
    ga = 0;
    gw = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin ga = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin gw = 1; s_axi_wvalid <= 0; end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Counts indicator changes and gathers the colours lit in 24 cycles.
  // One edge passes first, so a change launched on entry is not counted.
  task automatic watch();
    n = 0;
    seen = 2'b00;
    @(posedge aclk);
    prev = led_reg;
    repeat (24) begin
      @(posedge aclk);
      if (led_reg !== prev) n++;
      prev = led_reg;
      seen = seen | led_reg;
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Too slow a run means a hang.
  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end
  initial begin
    // Each row: straps at reset and the address they must give.
    for (i = 0; i < 4; i++) begin
      strap <= rows[i][8:7];
      rst();
      `CHK({led_reg, fail_n_reg, backplane_hold_n_reg}, 6'h25)
      `WT(addr_valid_reg)
      `CHK(mgmt_addr_reg, rows[i][6:0])
      strap <= ~strap;
      repeat (30) @(posedge aclk);
      `CHK(mgmt_addr_reg, rows[i][6:0])
    end
    startup_done <= 1'b1;
    `WT(!backplane_hold_n_reg.oe)
    `CHK({led_reg.red, fail_n_reg.oe, backplane_hold_n_reg.oe}, 3'h0)
    wr(OFS_IRQ_MASK, 32'hF);
    `CHK(irq_reg, 1'b1)
    rdt(OFS_IRQ_STS);
    `CHK(rd[3:0], 4'hC)
    repeat (2) @(posedge aclk);
    `CHK(irq_reg, 1'b0)
    want_aux <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(aux_on_reg, 1'b0)
    `WT(aux_on_reg)
    watch();
    `CHK({aux_on_reg, main_on_reg, led_reg, n}, {4'h9, 32'h0})
    want_inhibit <= 1'b0;
    `WT(main_on_reg)
    `CHK(main_on_reg, 1'b1)
    // A quick off and on again must wait for the lockout to run out.
    want_inhibit <= 1'b1;
    `WT(!main_on_reg)
    want_inhibit <= 1'b0;
    repeat (20) @(posedge aclk);
    `CHK(main_on_reg, 1'b0)
    `WT(main_on_reg)
    `CHK(main_on_reg, 1'b1)
    want_aux <= 1'b0;
    `WT(!aux_on_reg)
    `CHK(main_on_reg, 1'b0)
    wr(OFS_CTRL, 32'h3);
    watch();
    `CHK({aux_on_reg, main_on_reg, seen, n > 4}, 5'h13)
    wr(OFS_CTRL, 32'h5);
    watch();
    `CHK(seen, 2'h3)
    // A write whose low strobe is off leaves the control bits alone.
    s_axi_wstrb <= 4'hE;
    wr(OFS_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    rdt(OFS_CTRL);
    `CHK(rd, 32'h5)
    // Every fault kind in turn, each cleared before the next.
    for (i = 0; i < 5; i++) begin
      fault_in <= 5'h10 >> i;
      `WT(fail_n_reg.oe)
      watch();
      `CHK({seen, backplane_hold_n_reg.oe, irq_reg, n > 0}, 5'h13)
      `CHK(led_reg.green, 1'b0)
      fault_in <= '0;
      `WT(!fail_n_reg.oe)
    end
    rdt(8'h10);
    `CHK({rs, rd}, {RESP_DECERR, 32'h0})
    fault_in <= '0;
    startup_done <= 1'b0;
    rst();
    repeat (110) @(posedge aclk);
    startup_done <= 1'b1;
    rdt(OFS_STATUS);
    `CHK({rd[2:0], led_reg, backplane_hold_n_reg.oe}, 6'h0D)
    end_of_test();
  end
endmodule
